/* src/pcp_port.v */
`timescale 1ns/1ns
`include "pcp_regs.vh"
module pcp_port #(
  parameter A_W = 2,
  parameter B_W = 8
) (
  input wire clk_sys,
  input wire reset,
  input wire [2:0] wr_sel,
  input wire wr_en,
  input wire [7:0] wr_data,
  input wire [2:0] rd_sel,
  output reg [7:0] rd_data,
  input wire [A_W-1:0] pin_a_in,
  output wire [A_W-1:0] pin_a_out,
  output wire [A_W-1:0] pin_a_oe_n,
  output wire [A_W-1:0] pin_a_pullup,
  input wire [B_W-1:0] pin_b_in,
  output wire [B_W-1:0] pin_b_out,
  output wire [B_W-1:0] pin_b_oe_n,
  output wire [B_W-1:0] pin_b_pullup,
  output wire [B_W-1:0] pin_b_strong,
  output wire [`PCP_ANA_N-1:0] analog_sel,
  input wire serial_data_output,
  output wire serial_clock_line,
  output wire serial_data_input,
  output wire pin_irq
);
  // port a lines are the high lines 4..7 of an 8-bit map when A_W is 4
  // ****************************************
  // registers
  // ****************************************
  reg [B_W-1:0] port_a_value_reg_q, a_dir_q, a_opt_q;
  reg [B_W-1:0] port_b_value_reg_q, b_dir_q, b_opt_q;
  reg [1:0] edge_select_reg_q;
  reg [A_W-1:0] a_s1_q, a_s2_q, a_s3_q;
  reg [B_W-1:0] b_s1_q, b_s2_q, b_s3_q;
  reg [A_W-1:0] a_lvl_q;
  reg [B_W-1:0] b_lvl_q;
  reg irq_q;
  wire [A_W-1:0] a_irq_en, a_ana;
  wire [B_W-1:0] b_irq_en, b_ana;
  wire [A_W-1:0] a_pos, a_neg;
  wire [B_W-1:0] b_pos, b_neg;
  wire [A_W-1:0] a_lvl_d;
  wire [B_W-1:0] b_lvl_d;
  wire [A_W-1:0] a_hit;
  wire [B_W-1:0] b_hit;
  wire [3:0] a_ana4;
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      port_a_value_reg_q <= `PCP_RST_VALUE;
      a_dir_q <= `PCP_RST_DIR;
      a_opt_q <= `PCP_RST_OPT;
      port_b_value_reg_q <= `PCP_RST_VALUE;
      b_dir_q <= `PCP_RST_DIR;
      b_opt_q <= `PCP_RST_OPT;
      edge_select_reg_q <= `PCP_RST_EDGE;
    end else if (wr_en) begin
      // the unused select falls to the default and writes nothing
      case (wr_sel)
        `PCP_SEL_A_VALUE: port_a_value_reg_q <= wr_data;
        `PCP_SEL_A_DIR: a_dir_q <= wr_data;
        `PCP_SEL_A_OPT: a_opt_q <= wr_data;
        `PCP_SEL_B_VALUE: port_b_value_reg_q <= wr_data;
        `PCP_SEL_B_DIR: b_dir_q <= wr_data;
        `PCP_SEL_B_OPT: b_opt_q <= wr_data;
        `PCP_SEL_EDGE: edge_select_reg_q <= wr_data[1:0];
        default: edge_select_reg_q <= edge_select_reg_q;
      endcase
    end
  end
  // ****************************************
  // pin synchronisers
  // ****************************************
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      a_s1_q <= {A_W{`PCP_RST_LEVEL}};
      a_s2_q <= {A_W{`PCP_RST_LEVEL}};
      a_s3_q <= {A_W{`PCP_RST_LEVEL}};
      b_s1_q <= {B_W{`PCP_RST_LEVEL}};
      b_s2_q <= {B_W{`PCP_RST_LEVEL}};
      b_s3_q <= {B_W{`PCP_RST_LEVEL}};
      a_lvl_q <= {A_W{`PCP_RST_LEVEL}};
      b_lvl_q <= {B_W{`PCP_RST_LEVEL}};
      irq_q <= 1'b0;
    end else begin
      a_s1_q <= pin_a_in;
      a_s2_q <= a_s1_q;
      a_s3_q <= a_s2_q;
      b_s1_q <= pin_b_in;
      b_s2_q <= b_s1_q;
      b_s3_q <= b_s2_q;
      a_lvl_q <= a_lvl_d;
      b_lvl_q <= b_lvl_d;
      // one-cycle pulse per detected edge; the core latches it
      irq_q <= (|a_hit) | (|b_hit);
    end
  end
  // level changes only when stages two and three agree, filtering a glitch
  assign a_lvl_d = (a_s2_q & a_s3_q) | (a_lvl_q & (a_s2_q ^ a_s3_q));
  assign b_lvl_d = (b_s2_q & b_s3_q) | (b_lvl_q & (b_s2_q ^ b_s3_q));
  assign a_pos = a_lvl_d & ~a_lvl_q;
  assign a_neg = ~a_lvl_d & a_lvl_q;
  assign b_pos = b_lvl_d & ~b_lvl_q;
  assign b_neg = ~b_lvl_d & b_lvl_q;
  assign pin_irq = irq_q;
  // ****************************************
  // interrupt combine
  // ****************************************
  // only lines in the interrupt input code take part; a mode change is no edge
  assign a_hit = a_irq_en & (edge_select_reg_q[`PCP_EDGE_A] ? a_pos : a_neg);
  assign b_hit = b_irq_en & (edge_select_reg_q[`PCP_EDGE_B] ? b_pos : b_neg);
  // ****************************************
  // line decode
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < A_W; i = i + 1) begin : g_a
      pcp_line #(.ANALOG((`PCP_A_ANALOG >> (i + 8 - A_W)) & 1), .SINK(0)) u_line (
        .dir(a_dir_q[i + 8 - A_W]),
        .opt(a_opt_q[i + 8 - A_W]),
        .val(port_a_value_reg_q[i + 8 - A_W]),
        .alt_en(1'b0),
        .alt_val(1'b0),
        .drive_oe_n(pin_a_oe_n[i]),
        .drive_out(pin_a_out[i]),
        .pullup_en(pin_a_pullup[i]),
        .irq_en(a_irq_en[i]),
        .analog_en(a_ana[i]),
        .strong_sink()
      );
    end
    for (i = 0; i < B_W; i = i + 1) begin : g_b
      pcp_line #(.ANALOG((`PCP_B_ANALOG >> i) & 1), .SINK((`PCP_B_SINK >> i) & 1)) u_line (
        .dir(b_dir_q[i]),
        .opt(b_opt_q[i]),
        .val(port_b_value_reg_q[i]),
        .alt_en(i == `PCP_SERIAL_DATA_OUTPUT_BIT),
        .alt_val(serial_data_output),
        .drive_oe_n(pin_b_oe_n[i]),
        .drive_out(pin_b_out[i]),
        .pullup_en(pin_b_pullup[i]),
        .irq_en(b_irq_en[i]),
        .analog_en(b_ana[i]),
        .strong_sink(pin_b_strong[i])
      );
    end
  endgenerate
  // ****************************************
  // converter select map
  // ****************************************
  // port a sits at the top of the 8-bit map; lines absent on a narrow port never select
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_ana
      if (i + A_W >= 4) begin : g_line
        assign a_ana4[i] = a_ana[i + A_W - 4];
      end else begin : g_none
        // no such line on this port width
        assign a_ana4[i] = 1'b0;
      end
    end
  endgenerate
  // converter selects: port a lines 4..7 then port b lines 2..3; one at a time is software's duty
  assign analog_sel = {b_ana[3], b_ana[2], a_ana4};
  // ****************************************
  // serial lines
  // ****************************************
  // filtered levels only: the serial clock rate is limited by the filter delay
  assign serial_clock_line = b_lvl_q[`PCP_SCK_BIT];
  assign serial_data_input = b_lvl_q[`PCP_SIN_BIT];
  // ****************************************
  // read back
  // ****************************************
  wire [7:0] a_pins8 = {a_lvl_q, {(8-A_W){1'b0}}};
  // input lines read the filtered pin, output lines the latch
  function [7:0] pcp_rd_mix;
    input [7:0] latch;
    input [7:0] dir;
    input [7:0] pins;
    begin
      pcp_rd_mix = (latch & dir) | (pins & ~dir);
    end
  endfunction
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rd_data <= 8'h00;
    end else begin
      case (rd_sel)
        `PCP_SEL_A_VALUE: rd_data <= pcp_rd_mix(port_a_value_reg_q, a_dir_q, a_pins8);
        `PCP_SEL_A_DIR: rd_data <= a_dir_q;
        `PCP_SEL_A_OPT: rd_data <= a_opt_q;
        `PCP_SEL_B_VALUE: rd_data <= pcp_rd_mix(port_b_value_reg_q, b_dir_q, b_lvl_q);
        `PCP_SEL_B_DIR: rd_data <= b_dir_q;
        `PCP_SEL_B_OPT: rd_data <= b_opt_q;
        `PCP_SEL_EDGE: rd_data <= {6'h00, edge_select_reg_q};
        default: rd_data <= 8'h00;
      endcase
    end
  end
endmodule // pcp_port

/* src/pcp_regs.vh */
`ifndef PCP_REGS_VH
`define PCP_REGS_VH
// ****************************************
// reset values and code fields
// ****************************************
`define PCP_RST_VALUE 8'h00
`define PCP_RST_DIR 8'h00
`define PCP_RST_OPT 8'h00
`define PCP_RST_EDGE 2'h0
// synchroniser reset level: the idle level of a pulled-up input
`define PCP_RST_LEVEL 1'b1
// register selects, shared by the write and read ports
`define PCP_SEL_A_VALUE 3'h0
`define PCP_SEL_A_DIR 3'h1
`define PCP_SEL_A_OPT 3'h2
`define PCP_SEL_B_VALUE 3'h3
`define PCP_SEL_B_DIR 3'h4
`define PCP_SEL_B_OPT 3'h5
`define PCP_SEL_EDGE 3'h6
// edge select bit positions, one per port
`define PCP_EDGE_A 0
`define PCP_EDGE_B 1
// port a analog lines 4..7, port b analog lines 2..3
`define PCP_A_ANALOG 8'hf0
`define PCP_B_ANALOG 8'h0c
// port b high sink lines 4..7
`define PCP_B_SINK 8'hf0
// port b serial lines
`define PCP_SCK_BIT 5
`define PCP_SIN_BIT 6
`define PCP_SERIAL_DATA_OUTPUT_BIT 7
// analog select vector width, one bit per analog line, 6 analog lines
`define PCP_ANA_N 6
`endif

/* src/pcp_line.v */
`timescale 1ns/1ns
// ****************************************
// one pin line: mode decode
// ****************************************
module pcp_line #(
  parameter ANALOG = 0,
  parameter SINK = 0
) (
  input wire dir,
  input wire opt,
  input wire val,
  input wire alt_en,
  input wire alt_val,
  output reg drive_oe_n,
  output reg drive_out,
  output reg pullup_en,
  output reg irq_en,
  output reg analog_en,
  output reg strong_sink
);
  always @* begin
    drive_oe_n = 1'b1;
    drive_out = 1'b0;
    pullup_en = 1'b0;
    irq_en = 1'b0;
    analog_en = 1'b0;
    strong_sink = 1'b0;
    case ({dir, opt, val})
      3'b000: pullup_en = 1'b1;
      3'b001: pullup_en = 1'b0;
      3'b010: begin
        pullup_en = 1'b1;
        irq_en = 1'b1;
      end
      3'b011: analog_en = (ANALOG != 0);
      3'b100, 3'b101: begin
        // open drain: only low is driven; serial out may replace the value
        drive_out = 1'b0;
        drive_oe_n = alt_en ? alt_val : val;
        strong_sink = (SINK != 0);
      end
      3'b110, 3'b111: begin
        drive_oe_n = 1'b0;
        drive_out = val;
        strong_sink = (SINK != 0);
      end
      default: drive_oe_n = 1'b1;
    endcase
  end
endmodule // pcp_line

/* verif/pcp_port_properties.sv */
`timescale 1ns/1ns
`include "pcp_regs.vh"
// ****************
// pin mode checks
// ****************
module pcp_port_properties #(parameter A_W = 2, parameter B_W = 8) (
  input wire clk_sys,
  input wire reset,
  input wire [2:0] wr_sel,
  input wire wr_en,
  input wire [7:0] wr_data,
  input wire [2:0] rd_sel,
  input wire [7:0] rd_data,
  input wire [A_W-1:0] pin_a_oe_n,
  input wire [B_W-1:0] pin_b_in,
  input wire [B_W-1:0] pin_b_oe_n,
  input wire [B_W-1:0] pin_b_pullup,
  input wire [B_W-1:0] pin_b_strong,
  input wire [`PCP_ANA_N-1:0] analog_sel,
  input wire serial_clock_line,
  input wire serial_data_input
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_still; $stable(pin_b_in)[*4]; endsequence
  property p_sync; s_still |-> serial_clock_line == pin_b_in[5] && serial_data_input == pin_b_in[6]; endproperty
  a_sync: assert property (p_sync) else $error("serial pins not followed");
  property p_nopull; ~|(pin_b_pullup & ~pin_b_oe_n); endproperty
  a_nopull: assert property (p_nopull) else $error("pull-up on driven line");
  property p_sink; ~|(pin_b_strong & ~`PCP_B_SINK); endproperty
  a_sink: assert property (p_sink) else $error("strong sink on plain line");
  property p_bdir; wr_en && wr_sel == 3'h4 |=> &(pin_b_oe_n | $past(wr_data)); endproperty
  a_bdir: assert property (p_bdir) else $error("port b input line driven");
  property p_adir; wr_en && wr_sel == 3'h1 |=> &(pin_a_oe_n | $past(wr_data[7:8-A_W])); endproperty
  a_adir: assert property (p_adir) else $error("port a input line driven");
  property p_rdnone; rd_sel == 3'h7 |=> rd_data == 8'h00; endproperty
  a_rdnone: assert property (p_rdnone) else $error("unused read not zero");
  property p_rddir; rd_sel == 3'h4 && !wr_en |=> &(rd_data | pin_b_oe_n); endproperty
  a_rddir: assert property (p_rddir) else $error("driven line without direction");
  property p_analog; analog_sel[5] |-> pin_b_oe_n[3] && !pin_b_pullup[3]; endproperty
  a_analog: assert property (p_analog) else $error("analog line not released");
endmodule // pcp_port_properties
bind pcp_port pcp_port_properties #(.A_W(A_W), .B_W(B_W)) u_props (.clk_sys(clk_sys), .reset(reset),
  .wr_sel(wr_sel), .wr_en(wr_en), .wr_data(wr_data), .rd_sel(rd_sel), .rd_data(rd_data),
  .pin_a_oe_n(pin_a_oe_n), .pin_b_in(pin_b_in), .pin_b_oe_n(pin_b_oe_n), .pin_b_pullup(pin_b_pullup),
  .pin_b_strong(pin_b_strong), .analog_sel(analog_sel), .serial_clock_line(serial_clock_line),
  .serial_data_input(serial_data_input));

/* verif/pcp_board.sv */
`timescale 1ns/1ns
// ****************
// board side of one port
// ****************
module pcp_board #(parameter W = 8) (
  input wire clk_sys,
  input wire [W-1:0] pin_out,
  input wire [W-1:0] pin_oe_n,
  input wire [W-1:0] pin_pullup,
  input wire [W-1:0] ext_en,
  input wire [W-1:0] ext_val,
  output wire [W-1:0] pin_level
);
  reg flt_q = 1'b0;
  // an unpulled, undriven line wanders, so no stale level is trusted
  always @(posedge clk_sys) flt_q <= ~flt_q;
  assign pin_level = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val) |
    (pin_oe_n & ~ext_en & pin_pullup) | (pin_oe_n & ~ext_en & ~pin_pullup & {W{flt_q}});
endmodule // pcp_board

/* verif/pcp_port_tb_top.sv */
`timescale 1ns/1ns
// ****************
// port configuration bench
// ****************
module pcp_port_tb_top;
  reg clk_sys, reset, wr_en, sdo;
  reg [2:0] wr_sel, rd_sel;
  reg [7:0] wr_data, ext_b, v;
  reg [1:0] ext_a;
  wire [7:0] rd_data, b_in, b_out, b_oe_n, b_pu, b_st;
  wire [1:0] a_in, a_out, a_oe_n, a_pu;
  wire [5:0] ana;
  wire sck, sdi, irq;
  integer miscompares, cmp_count, i, n;
  pcp_port dut (.clk_sys(clk_sys), .reset(reset), .wr_sel(wr_sel), .wr_en(wr_en), .wr_data(wr_data),
    .rd_sel(rd_sel), .rd_data(rd_data), .pin_a_in(a_in), .pin_a_out(a_out), .pin_a_oe_n(a_oe_n),
    .pin_a_pullup(a_pu), .pin_b_in(b_in), .pin_b_out(b_out), .pin_b_oe_n(b_oe_n), .pin_b_pullup(b_pu),
    .pin_b_strong(b_st), .analog_sel(ana), .serial_data_output(sdo), .serial_clock_line(sck),
    .serial_data_input(sdi), .pin_irq(irq));
  pcp_board #(.W(2)) board_a (.clk_sys(clk_sys), .pin_out(a_out), .pin_oe_n(a_oe_n), .pin_pullup(a_pu),
    .ext_en(2'h3), .ext_val(ext_a), .pin_level(a_in));
  pcp_board #(.W(8)) board_b (.clk_sys(clk_sys), .pin_out(b_out), .pin_oe_n(b_oe_n), .pin_pullup(b_pu),
    .ext_en(8'hff), .ext_val(ext_b), .pin_level(b_in));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [2:0] s, input [7:0] d);
    begin
      @(posedge clk_sys);
      wr_sel <= s;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk_sys);
      wr_en <= 1'b0;
      @(negedge clk_sys);
    end
  endtask
  task rd(input [2:0] s);
    begin
      @(posedge clk_sys);
      rd_sel <= s;
      @(posedge clk_sys);
      @(negedge clk_sys);
      v = rd_data;
    end
  endtask
  task irqs;
    begin
      n = 0;
      repeat (8) begin
        @(negedge clk_sys);
        if (irq === 1'b1) n = n + 1;
      end
    end
  endtask
  task tally_and_finish;
    begin
      if (miscompares == 0 && cmp_count > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    miscompares = 0;
    cmp_count = 0;
    {reset, wr_en, wr_sel, wr_data, rd_sel, sdo, ext_a, ext_b} = {1'b1, 18'h0, 8'h7c};
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys);
    chk(b_oe_n & b_pu, 8'hff);
    chk({6'h0, a_oe_n & a_pu}, 8'h03);
    chk(rd_data | {7'h0, irq}, 8'h00);
    wr(3'h6, 8'h01);
    @(posedge clk_sys) ext_a <= 2'b10;
    irqs;
    chk(n[7:0], 8'h00);
    wr(3'h2, 8'h80);
    for (i = 0; i < 2; i = i + 1) begin
      wr(3'h6, i[7:0]);
      @(posedge clk_sys) ext_a <= 2'b00;
      irqs;
      chk(n[7:0], {7'h0, ~i[0]});
      @(posedge clk_sys) ext_a <= 2'b10;
      irqs;
      chk(n[7:0], {7'h0, i[0]});
    end
    wr(3'h1, 8'h40);
    chk({6'h0, a_oe_n}, 8'h02);
    // ram copy of the port a value byte, changed bitwise and written whole
    v = 8'h00;
    v[6] = 1'b1;
    wr(3'h0, v);
    wr(3'h2, 8'hc0);
    chk({6'h0, a_out & ~a_oe_n}, 8'h01);
    rd(3'h0);
    chk(v, 8'hc0);
    rd(3'h2);
    chk(v, 8'hc0);
    // value first, then option, then direction: a safe order, one analog line only
    wr(3'h3, 8'haa);
    wr(3'h5, 8'hcc);
    wr(3'h4, 8'hf0);
    chk(b_oe_n, 8'h2f);
    chk(b_out & ~b_oe_n, 8'h80);
    chk(b_pu, 8'h05);
    chk(b_st, 8'hf0);
    chk({2'h0, ana}, 8'h20);
    rd(3'h3);
    chk(v, 8'hac);
    rd(3'h4);
    chk(v, 8'hf0);
    rd(3'h7);
    chk(v, 8'h00);
    wr(3'h7, 8'hff);
    rd(3'h6);
    chk(v, 8'h01);
    rd(3'h5);
    chk(v, 8'hcc);
    wr(3'h5, 8'h4c);
    for (i = 0; i < 2; i = i + 1) begin
      @(posedge clk_sys) sdo <= i[0];
      @(negedge clk_sys);
      chk({7'h0, b_oe_n[7]}, {7'h0, i[0]});
    end
    @(posedge clk_sys) reset <= 1'b1;
    @(posedge clk_sys) reset <= 1'b0;
    @(negedge clk_sys);
    chk(b_oe_n & b_pu, 8'hff);
    wr(3'h4, 8'h00);
    @(posedge clk_sys) ext_b <= 8'h5c;
    repeat (6) @(negedge clk_sys);
    chk({6'h0, sck, sdi}, 8'h01);
    @(posedge clk_sys) ext_b <= 8'h3c;
    repeat (6) @(negedge clk_sys);
    chk({6'h0, sck, sdi}, 8'h02);
    wr(3'h5, 8'h04);
    @(posedge clk_sys) ext_b <= 8'h38;
    irqs;
    chk(n[7:0], 8'h01);
    @(posedge clk_sys) ext_b <= 8'h3c;
    irqs;
    chk(n[7:0], 8'h00);
    tally_and_finish;
  end
endmodule // pcp_port_tb_top
